// ---- rtl/ric_defines.vh ----
/*
 * Constants for the reset and interrupt control block: the register
 * offset, vector addresses, the unused vector byte and timing counts.
 * Assumes it is included by bare name into each design file that uses it.
 */
`ifndef RIC_DEFINES_VH
`define RIC_DEFINES_VH

// Register and vector addresses.
`define RIC_WDOG_SERVICE_ADDR 13'h1FF0
`define RIC_VEC_RESET 13'h1FFE
`define RIC_VEC_TRAP 13'h1FFC
`define RIC_VEC_EXT 13'h1FFA
`define RIC_VEC_TIMER 13'h1FF8
`define RIC_VEC_NONE 13'h0000

// Reset value of the unused vector low byte seen at the service location.
`define RIC_UNUSED_VEC_LSB 8'h00

// Watchdog: 18 stages clocked by the internal bus clock.
`define RIC_WDOG_STAGES 18
`define RIC_WDOG_TIMEOUT_US 65500
`define RIC_WDOG_CYCLES 18'h3FFFF

// Power-up stabilisation delay, in internal clock cycles.
`define RIC_POR_CYCLES 12'hFE0

// Length of the watchdog reset pulse, in clocks.
`define RIC_WDOG_PULSE 3'h4

// Clocks after an external take until the edge latch clears.
`define RIC_EXT_CLR_DELAY 4'h9

`endif

// ---- rtl/ric_top.v ----
/*
 * Reset and interrupt control: merges the external reset pin, the
 * power-up delay and the watchdog into one registered reset, and
 * arbitrates the hardware interrupt sources into a vector address.
 * Assumes the CPU core pulses the instruction boundary, acknowledges a
 * taken interrupt and reads vectors through the vector address port.
 * Pins (reset, interrupt, key inputs, programming voltage detect) are
 * asynchronous; timer flags and CPU strobes are on SYS_CLK_IN.
 */
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`include "ric_defines.vh"

module ric_top (
	// Clock, reset and enable.
	input wire SYS_CLK_IN,
	input wire RESET_IN,
	input wire CLK_EN_IN,
	// Pins.
	input wire RESET_PIN_N_IN,
	input wire EXT_IRQ_N_IN,
	input wire PROG_VOLT_IN,
	input wire [7:0] KEY_N_IN,
	// Option register bits.
	input wire OPT_WDOG_EN_IN,
	input wire OPT_LEVEL_IN,
	input wire [7:0] OPT_KEY_EN_IN,
	// Timer flags and enables.
	input wire CAPTURE_FLAG_IN,
	input wire COMPARE_FLAG_IN,
	input wire ROLLOVER_FLAG_IN,
	input wire CAPTURE_EN_IN,
	input wire COMPARE_EN_IN,
	input wire ROLLOVER_EN_IN,
	// CPU core handshake.
	input wire MASK_BIT_IN,
	input wire INSTR_BOUNDARY_IN,
	input wire TRAP_INSTR_IN,
	input wire RETURN_INSTR_IN,
	input wire VEC_READ_IN,
	input wire [12:0] VEC_ADDR_IN,
	// Register port.
	input wire [12:0] REG_ADDR_IN,
	input wire [7:0] REG_WDATA_IN,
	input wire REG_WR_IN,
	input wire REG_RD_IN,
	output reg [7:0] REG_RDATA_OUT,
	// Outputs to CPU and peripherals.
	output reg INT_RESET_OUT,
	output reg SET_MASK_OUT,
	output reg TAKE_INT_OUT,
	output reg [12:0] VECTOR_OUT,
	output reg WDOG_RESET_OUT,
	output reg POR_ACTIVE_OUT,
	output reg EXT_PENDING_OUT
);

	// Synchroniser stages for all asynchronous pins.
	reg [1:0] rst_pin_sync_ff;
	reg [1:0] irq_sync_ff;
	reg [1:0] pv_sync_ff;
	reg [7:0] key_sync1_ff;
	reg [7:0] key_sync2_ff;
	reg irq_prev_ff;
	reg [7:0] key_prev_ff;

	// Power-up, watchdog and edge latch state.
	reg [11:0] por_cnt_ff;
	reg por_ff;
	reg [17:0] wdog_cnt_ff;
	reg [2:0] wdog_pulse_ff;
	reg edge_latch_ff;
	reg [3:0] ext_clr_cnt_ff;
	reg ext_clr_run_ff;

	// Interrupt sequencing.
	localparam ST_RUN = 2'h0;
	localparam ST_VEC = 2'h1;
	reg [1:0] state_ff;
	reg [1:0] nxt_state;

	wire rst_pin_low = ~rst_pin_sync_ff[1];
	wire irq_low = ~irq_sync_ff[1];
	wire prog_volt = pv_sync_ff[1];
	wire [7:0] key_low = ~key_sync2_ff & OPT_KEY_EN_IN;
	wire irq_fall = ~irq_prev_ff & irq_low;
	wire key_fall = |(key_low & ~key_prev_ff);
	wire wdog_active = OPT_WDOG_EN_IN & ~prog_volt;
	wire wdog_hit = REG_WR_IN & (REG_ADDR_IN == `RIC_WDOG_SERVICE_ADDR);
	wire wdog_expire = wdog_active &
		(wdog_cnt_ff == `RIC_WDOG_CYCLES);
	wire ext_level = OPT_LEVEL_IN & (irq_low | (|key_low));
	wire ext_req = edge_latch_ff | ext_level;
	wire timer_req = (CAPTURE_FLAG_IN & CAPTURE_EN_IN) |
		(COMPARE_FLAG_IN & COMPARE_EN_IN) |
		(ROLLOVER_FLAG_IN & ROLLOVER_EN_IN);
	wire hw_req = ~MASK_BIT_IN & (ext_req | timer_req);
	wire any_reset = rst_pin_low | por_ff | (|wdog_pulse_ff);
	reg [12:0] nxt_vector;

	// Two flops ahead of all logic; the first stage feeds only the second.
	always @(posedge SYS_CLK_IN) begin
		if (RESET_IN) begin
			rst_pin_sync_ff <= 2'h3;
			irq_sync_ff <= 2'h3;
			pv_sync_ff <= 2'h0;
			key_sync1_ff <= 8'hFF;
			key_sync2_ff <= 8'hFF;
			irq_prev_ff <= 1'b0;
			key_prev_ff <= 8'h00;
		end else if (CLK_EN_IN) begin
			rst_pin_sync_ff <= {rst_pin_sync_ff[0], RESET_PIN_N_IN};
			irq_sync_ff <= {irq_sync_ff[0], EXT_IRQ_N_IN};
			pv_sync_ff <= {pv_sync_ff[0], PROG_VOLT_IN};
			key_sync1_ff <= KEY_N_IN;
			key_sync2_ff <= key_sync1_ff;
			irq_prev_ff <= irq_low;
			key_prev_ff <= key_low;
		end
	end

	// Power-up delay counts from oscillator start, taken as reset release.
	always @(posedge SYS_CLK_IN) begin
		if (RESET_IN) begin
			por_cnt_ff <= 12'h000;
			por_ff <= 1'b1;
		end else if (CLK_EN_IN && por_ff) begin
			if (por_cnt_ff == `RIC_POR_CYCLES - 12'h001) begin
				por_ff <= 1'b0;
			end else begin
				por_cnt_ff <= por_cnt_ff + 12'h001;
			end
		end
	end

	// Watchdog counter; any write to the service byte clears it, whatever
	// the data, and the stored vector byte is not altered.
	always @(posedge SYS_CLK_IN) begin
		if (RESET_IN) begin
			wdog_cnt_ff <= 18'h00000;
			wdog_pulse_ff <= 3'h0;
		end else if (CLK_EN_IN) begin
			if (wdog_hit || any_reset || !wdog_active) begin
				wdog_cnt_ff <= 18'h00000;
			end else begin
				wdog_cnt_ff <= wdog_cnt_ff + 18'h00001;
			end
			if (wdog_expire) begin
				wdog_pulse_ff <= `RIC_WDOG_PULSE;
			end else if (wdog_pulse_ff != 3'h0) begin
				wdog_pulse_ff <= wdog_pulse_ff - 3'h1;
			end
		end
	end

	// Edge latch: a new edge wins over a clear in the same cycle; one seen earlier in the clear delay is still cleared.
	always @(posedge SYS_CLK_IN) begin
		if (RESET_IN || any_reset) begin
			edge_latch_ff <= 1'b0;
			ext_clr_cnt_ff <= 4'h0;
			ext_clr_run_ff <= 1'b0;
		end else if (CLK_EN_IN) begin
			if (irq_fall || key_fall) begin
				edge_latch_ff <= 1'b1;
			end else if (ext_clr_run_ff &&
				ext_clr_cnt_ff == `RIC_EXT_CLR_DELAY - 4'h1) begin
				edge_latch_ff <= 1'b0;
			end
			if (TAKE_INT_OUT && VECTOR_OUT == `RIC_VEC_EXT) begin
				ext_clr_run_ff <= 1'b1;
				ext_clr_cnt_ff <= 4'h0;
			end else if (ext_clr_run_ff) begin
				if (ext_clr_cnt_ff == `RIC_EXT_CLR_DELAY - 4'h1) begin
					ext_clr_run_ff <= 1'b0;
				end
				ext_clr_cnt_ff <= ext_clr_cnt_ff + 4'h1;
			end
		end
	end

	// Priority reset, external, timer, then trap; only level and latch feed the external
	// request, so edge-only mode never looks at the pin itself.
	always @* begin
		nxt_vector = `RIC_VEC_NONE;
		if (any_reset) begin
			nxt_vector = `RIC_VEC_RESET;
		end else if (hw_req && ext_req) begin
			nxt_vector = `RIC_VEC_EXT;
		end else if (hw_req && timer_req) begin
			nxt_vector = `RIC_VEC_TIMER;
		end else if (TRAP_INSTR_IN) begin
			nxt_vector = `RIC_VEC_TRAP;
		end
	end

	// Hardware requests act only at a boundary; pending ones go before
	// the trap, which in turn ignores the mask.
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RUN: begin
				if (INSTR_BOUNDARY_IN && !any_reset &&
					(hw_req || TRAP_INSTR_IN)) begin
					nxt_state = ST_VEC;
				end
			end
			ST_VEC: begin
				if (VEC_READ_IN || RETURN_INSTR_IN) begin
					nxt_state = ST_RUN;
				end
			end
			default: begin
				nxt_state = ST_RUN;
			end
		endcase
	end

	// Output registers; the return is handled by the core restoring the
	// stacked state, after which pending requests are evaluated afresh.
	always @(posedge SYS_CLK_IN) begin
		if (RESET_IN) begin
			state_ff <= ST_RUN;
			INT_RESET_OUT <= 1'b1;
			SET_MASK_OUT <= 1'b1;
			TAKE_INT_OUT <= 1'b0;
			VECTOR_OUT <= `RIC_VEC_RESET;
			WDOG_RESET_OUT <= 1'b0;
			POR_ACTIVE_OUT <= 1'b1;
			EXT_PENDING_OUT <= 1'b0;
			REG_RDATA_OUT <= 8'h00;
		end else if (CLK_EN_IN) begin
			state_ff <= any_reset ? ST_RUN : nxt_state;
			INT_RESET_OUT <= any_reset;
			WDOG_RESET_OUT <= |wdog_pulse_ff;
			POR_ACTIVE_OUT <= por_ff;
			EXT_PENDING_OUT <= ext_req;
			TAKE_INT_OUT <= (state_ff == ST_RUN) && (nxt_state == ST_VEC);
			if (any_reset || ((state_ff == ST_RUN) &&
				(nxt_state == ST_VEC))) begin
				VECTOR_OUT <= nxt_vector;
				SET_MASK_OUT <= 1'b1;
			end else begin
				SET_MASK_OUT <= 1'b0;
			end
			// Reads return the stored byte and leave the watchdog alone.
			if (REG_RD_IN && REG_ADDR_IN == `RIC_WDOG_SERVICE_ADDR) begin
				REG_RDATA_OUT <= `RIC_UNUSED_VEC_LSB;
			end else begin
				REG_RDATA_OUT <= 8'h00;
			end
		end
	end

endmodule // ric_top

// ---- bench/ric_top_asserts.sv ----
/* Checker for the ric_top ports.
 Assumes CLK_EN_IN stays high. */
`timescale 1ns/100ps
module ric_chk (
	// Watched ports.
	input wire SYS_CLK_IN,
	input wire RESET_IN,
	input wire EXT_IRQ_N_IN,
	input wire MASK_BIT_IN,
	input wire INSTR_BOUNDARY_IN,
	input wire TRAP_INSTR_IN,
	input wire [12:0] REG_ADDR_IN,
	input wire REG_RD_IN,
	input wire [7:0] REG_RDATA_OUT,
	input wire INT_RESET_OUT,
	input wire SET_MASK_OUT,
	input wire TAKE_INT_OUT,
	input wire [12:0] VECTOR_OUT,
	input wire POR_ACTIVE_OUT,
	input wire EXT_PENDING_OUT
);
	// One domain, so the clock and the disable are stated once.
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (RESET_IN);
	// A take answers the boundary of the cycle before.
	sequence s_take;
		INSTR_BOUNDARY_IN ##1 TAKE_INT_OUT;
	endsequence
	a_reset_vec: assert property (disable iff (1'b0) RESET_IN |=>
		INT_RESET_OUT && SET_MASK_OUT && VECTOR_OUT == 13'h1FFE)
		else $error("bad reset state");
	a_por_reset: assert property (POR_ACTIVE_OUT |-> INT_RESET_OUT)
		else $error("power-up without reset");
	a_take_cause: assert property (TAKE_INT_OUT |->
		$past(INSTR_BOUNDARY_IN))
		else $error("take off boundary");
	a_take_mask: assert property (s_take |-> SET_MASK_OUT &&
		VECTOR_OUT[12:3] == 10'h3FF && !VECTOR_OUT[0])
		else $error("bad take vector");
	a_mask_block: assert property (INSTR_BOUNDARY_IN && MASK_BIT_IN &&
		!TRAP_INSTR_IN |=> !TAKE_INT_OUT) else $error("masked take");
	a_trap_vec: assert property (TAKE_INT_OUT && VECTOR_OUT == 13'h1FFC
		|-> $past(TRAP_INSTR_IN)) else $error("trap without request");
	a_edge_latch: assert property ($fell(EXT_IRQ_N_IN) && !INT_RESET_OUT
		|-> ##[1:6] EXT_PENDING_OUT) else $error("edge not latched");
	a_reg_read: assert property (REG_RD_IN && REG_ADDR_IN == 13'h1FF0
		|=> REG_RDATA_OUT == 8'h00) else $error("bad service read");
endmodule // ric_chk
bind ric_top ric_chk u_chk (.SYS_CLK_IN, .RESET_IN, .EXT_IRQ_N_IN,
	.MASK_BIT_IN, .INSTR_BOUNDARY_IN, .TRAP_INSTR_IN, .REG_ADDR_IN,
	.REG_RD_IN, .REG_RDATA_OUT, .INT_RESET_OUT, .SET_MASK_OUT,
	.TAKE_INT_OUT, .VECTOR_OUT, .POR_ACTIVE_OUT, .EXT_PENDING_OUT);

// ---- bench/ric_cpu_model.sv ----
/* CPU core stand-in: boundary pulses and vector fetches.
 Assumes a take comes one cycle after a boundary. */
`timescale 1ns/100ps
module ric_cpu_model (
	// Clock and block answers.
	input wire clk_in,
	input wire take_in,
	input wire [12:0] vector_in,
	// Core strobes.
	output reg boundary_out = 1'b0,
	output reg vec_read_out = 1'b0,
	output reg [12:0] vec_addr_out = 13'h0000
);
	reg [1:0] step_ff = 2'h0;
	reg [1:0] fetch_ff = 2'h0;
	// Boundary every fourth cycle, none while a vector is fetched.
	always @(posedge clk_in) begin
		step_ff <= step_ff + 2'h1;
		boundary_out <= step_ff == 2'h3 && fetch_ff == 2'h0;
		fetch_ff <= take_in === 1'b1 ? 2'h2 :
			fetch_ff - {1'b0, fetch_ff != 2'h0};
		vec_read_out <= fetch_ff == 2'h1;
		// Idle address is inverted each cycle, so a stale value matches every second cycle.
		vec_addr_out <= fetch_ff == 2'h1 ? vector_in : ~vec_addr_out;
	end
endmodule // ric_cpu_model

// ---- bench/test_reset_and_interrupt_control.sv ----
/* Bench for ric_top with a CPU stand-in.
 Assumes the checker is bound in its own file. */
`timescale 1ns/100ps
module test_reset_and_interrupt_control;
	reg clk = 0, rst = 1, pin_n = 0, irq_n = 1, lvl = 0, mask = 1;
	reg trap = 0, ret = 0, wr = 0, rd = 0;
	reg [2:0] fl = 0, en = 7;
	reg [7:0] wd = 0;
	reg [12:0] ad = 0;
	wire [7:0] rdat;
	wire ires, take, bnd, vrd, pend, smask, por;
	wire [12:0] vec, va;
	integer miscompares = 0, num_checks = 0, i, k;
	// Clock at 100 MHz.
	initial forever #5 clk = ~clk;
	ric_top u_dut (.SYS_CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(1'b1),
		.RESET_PIN_N_IN(pin_n), .EXT_IRQ_N_IN(irq_n), .PROG_VOLT_IN(1'b0),
		.KEY_N_IN(8'hFF), .OPT_WDOG_EN_IN(1'b1), .OPT_LEVEL_IN(lvl),
		.OPT_KEY_EN_IN(8'h00), .CAPTURE_FLAG_IN(fl[0]),
		.COMPARE_FLAG_IN(fl[1]), .ROLLOVER_FLAG_IN(fl[2]),
		.CAPTURE_EN_IN(en[0]), .COMPARE_EN_IN(en[1]), .ROLLOVER_EN_IN(en[2]),
		.MASK_BIT_IN(mask), .INSTR_BOUNDARY_IN(bnd), .TRAP_INSTR_IN(trap),
		.RETURN_INSTR_IN(ret), .VEC_READ_IN(vrd), .VEC_ADDR_IN(va),
		.REG_ADDR_IN(ad), .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.REG_RDATA_OUT(rdat), .INT_RESET_OUT(ires), .SET_MASK_OUT(smask),
		.TAKE_INT_OUT(take), .VECTOR_OUT(vec), .WDOG_RESET_OUT(),
		.POR_ACTIVE_OUT(por), .EXT_PENDING_OUT(pend));
	ric_cpu_model u_cpu (.clk_in(clk), .take_in(take), .vector_in(vec),
		.boundary_out(bnd), .vec_read_out(vrd), .vec_addr_out(va));
	task print_verdict;
		if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input [12:0] got, input [12:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Sampling 1 ns after the edge lets that edge's updates land.
	task cyc(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task reg_rd(input [12:0] a, input [7:0] e);
		@(posedge clk) begin
			ad <= a;
			rd <= 1;
		end
		@(posedge clk) rd <= 0;
		#1 chk(rdat, e);
	endtask
	task reg_wr(input [12:0] a, input [7:0] d);
		@(posedge clk) begin
			ad <= a;
			wd <= d;
			wr <= 1;
		end
		@(posedge clk) wr <= 0;
	endtask
	// A missing take ends the run, since later steps depend on it. The
	// first step passes the calling edge, so the earliest take seen is one launched at the next edge.
	task wait_take(input [12:0] e);
		cyc(1);
		for (k = 0; k < 60 && take !== 1'b1; k = k + 1) cyc(1);
		if (take !== 1'b1) begin
			miscompares = miscompares + 1;
			print_verdict;
		end else begin
			chk(vec, e);
			chk(smask, 1);
		end
	endtask
	task no_take(input integer n);
		repeat (n) begin
			cyc(1);
			chk(take, 0);
		end
	endtask
	task t_por;
		cyc(4080);
		chk(ires, 1);
		@(posedge clk) pin_n <= 1;
		cyc(8);
		chk(ires, 0);
		@(posedge clk) rst <= 1;
		@(posedge clk) rst <= 0;
		cyc(4060);
		chk(ires, 1);
		chk(por, 1);
		cyc(12);
		chk(ires, 0);
		chk(por, 0);
	endtask
	task t_timer;
		for (i = 0; i < 3; i = i + 1) begin
			@(posedge clk) begin
				fl <= 3'h1 << i;
				en <= ~(3'h1 << i);
				mask <= 0;
			end
			no_take(12);
			@(posedge clk) en <= 3'h7;
			wait_take(13'h1FF8);
			@(posedge clk) begin
				mask <= 1;
				fl <= 0;
			end
			cyc(6);
		end
	endtask
	task t_prio;
		@(posedge clk) begin
			fl <= 3'h4;
			irq_n <= 0;
		end
		@(posedge clk) irq_n <= 1;
		no_take(8);
		chk(pend, 1);
		@(posedge clk) begin
			mask <= 0;
			trap <= 1;
		end
		wait_take(13'h1FFA);
		@(posedge clk) begin
			mask <= 1;
			fl <= 0;
		end
		wait_take(13'h1FFC);
		@(posedge clk) trap <= 0;
		cyc(12);
		chk(pend, 0);
	endtask
	task t_level;
		@(posedge clk) begin
			lvl <= 1;
			irq_n <= 0;
			mask <= 0;
		end
		wait_take(13'h1FFA);
		@(posedge clk) mask <= 1;
		cyc(12);
		@(posedge clk) begin
			ret <= 1;
			mask <= 0;
		end
		@(posedge clk) ret <= 0;
		wait_take(13'h1FFA);
		@(posedge clk) begin
			mask <= 1;
			lvl <= 0;
		end
		cyc(12);
		@(posedge clk) mask <= 0;
		no_take(20);
	endtask
	// Reset held for two cycles, then each scenario in turn.
	initial begin
		repeat (2) @(posedge clk);
		rst <= 0;
		t_por;
		reg_rd(13'h1FF0, 8'h00);
		reg_rd(13'h1F00, 8'h00);
		reg_wr(13'h1FF0, 8'hFE);
		reg_rd(13'h1FF0, 8'h00);
		t_timer;
		t_prio;
		t_level;
		print_verdict;
	end
endmodule // test_reset_and_interrupt_control
